// >>> motor_protection_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// [R1] Undercurrent check before bypass trips, disables motor
// [R2] Check off: low current motors still start
// [R3] Twice nominal current blocks bypass, raises fault
// [R4] Bypass not opening after stop raises fault
// [R5] Run waits pre-start delay, at least 0.5 s
// [R6] Start inhibited post-stop time, at least 2 s
// [R7] Run commands during inhibit are discarded
// [R8] Three-wire clears request; two-wire held starts
// [R9] Start before minimum interval raises fault
// [R10] Inactive channel reads zero degrees
// [R11] Above fault level in fault mode disables
// [R12] Above alarm level raises alarm, keeps running
// [R13] Alarm clears below alarm reset level
// [R14] Software keeps alarm level above reset level
// [R15] Mode: fault, alarm, or both levels
// [R16] Nonzero installed code enables channel protections
// [R17] Sensor short/open: fault or alarm by mode
// [R18] Four identical independent temperature channels
// [R19] Settings change only while motor stopped
// [R20] Timers tick every 0.1 s, cleared at reset
module motor_protection_supervisor #(
   parameter int TICK_CYCLES = mps_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire mps_pkg::bus_req_t bus,
   output logic [mps_pkg::DW-1:0] rdata,
   input wire logic run_cmd,
   input wire logic run_level,
   input wire logic stop_cmd,
   input wire logic start_done,
   input wire logic decel_done,
   input wire logic bypass_fb,
   input wire logic [15:0] motor_current,
   input wire mps_pkg::chan_in_t [mps_pkg::NCH-1:0] chan_in,
   output logic motor_run,
   output logic bypass_close,
   output logic motor_disable,
   output logic [15:0] faults,
   output logic [11:0] alarms
);
   localparam int TKW = $clog2(TICK_CYCLES);

   typedef struct packed {
      mps_pkg::st_t st;
      logic [mps_pkg::TMW-1:0] tmr;
      logic [mps_pkg::TMW-1:0] ivl;
      logic [TKW-1:0] tick;
      logic [3:0] stuck;
      logic bypass;
      logic [15:0] flt;
      mps_pkg::ctrl_t ctrl;
      logic [15:0] pre;
      logic [15:0] post;
      logic [15:0] ivl_s;
      logic [15:0] mot_nom;
      logic [15:0] starter_nom;
      mps_pkg::chan_cfg_t [mps_pkg::NCH-1:0] ccfg;
      logic [mps_pkg::DW-1:0] rdata;
   } state_t;

   state_t s_r, s_nxt;
   logic [1:0] rsync_r;
   logic rst_n;
   mps_pkg::chan_out_t [mps_pkg::NCH-1:0] cout;
   logic tick_p, start_req, stopped, running, uc_bad, oc_bad;
   logic [15:0] flt_set;

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo);
      clamp = (v < lo) ? lo : ((v > mps_pkg::TIME_MAX) ? mps_pkg::TIME_MAX : v);
   endfunction

   // ==========================================================
   // Reset release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsync_r <= '0;
      end else begin
         rsync_r <= {rsync_r[0], 1'b1};
      end
   end
   assign rst_n = rsync_r[1];

   // ==========================================================
   // Temperature channels
   genvar gi;
   generate
      for (gi = 0; gi < mps_pkg::NCH; gi++) begin : g_ch
         temp_channel u_ch ( // R18
            .clk(clk),
            .rst_n(rst_n),
            .cfg(s_r.ccfg[gi]),
            .din(chan_in[gi]),
            .dout(cout[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Sequencer, protections and registers
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = '0;
      flt_set = '0;
      tick_p = s_r.tick == TKW'(TICK_CYCLES - 1);
      s_nxt.tick = tick_p ? '0 : s_r.tick + 1'b1; // R20
      start_req = run_cmd | (s_r.ctrl.two_wire & run_level); // R8
      stopped = (s_r.st == mps_pkg::ST_IDLE) || (s_r.st == mps_pkg::ST_INHIBIT);
      running = !stopped;
      uc_bad = s_r.ctrl.uc_en
         && ((20'(motor_current) * mps_pkg::UC_DIV) < 20'(s_r.starter_nom)); // R1 R2
      oc_bad = s_r.ctrl.oc_en
         && (17'(motor_current) >= 17'(s_r.mot_nom) * mps_pkg::OC_MUL); // R3
      if (tick_p && s_r.ivl != '0) begin
         s_nxt.ivl = s_r.ivl - 1'b1;
      end
      if (s_r.st != mps_pkg::ST_INHIBIT) begin
         s_nxt.stuck = '0;
      end

      unique case (s_r.st)
         mps_pkg::ST_IDLE: begin
            if (start_req && !motor_disable) begin
               if (s_r.ivl != '0) begin
                  flt_set[mps_pkg::FLT_IVL] = 1'b1; // R9
               end else begin
                  s_nxt.st = mps_pkg::ST_DELAY; // R5
                  s_nxt.tmr = mps_pkg::TMW'(s_r.pre);
                  s_nxt.ivl = mps_pkg::TMW'(s_r.ivl_s * mps_pkg::TICKS_PER_S); // R9
               end
            end
         end
         mps_pkg::ST_DELAY: begin
            if (stop_cmd) begin
               s_nxt.st = mps_pkg::ST_IDLE;
            end else if (tick_p) begin
               s_nxt.tmr = s_r.tmr - 1'b1; // R5
               if (s_r.tmr <= mps_pkg::TMW'(1)) begin
                  s_nxt.st = mps_pkg::ST_START;
               end
            end
         end
         mps_pkg::ST_START: begin
            if (stop_cmd) begin
               s_nxt.st = s_r.ctrl.decel_en ? mps_pkg::ST_DECEL : mps_pkg::ST_INHIBIT;
               s_nxt.tmr = mps_pkg::TMW'(s_r.post); // R6
            end else if (start_done) begin
               flt_set[mps_pkg::FLT_UC] = uc_bad; // R1
               flt_set[mps_pkg::FLT_OC] = oc_bad; // R3
               if (!uc_bad && !oc_bad) begin
                  s_nxt.st = mps_pkg::ST_BYPASS;
                  s_nxt.bypass = 1'b1; // R2
               end
            end
         end
         mps_pkg::ST_BYPASS: begin
            if (stop_cmd) begin
               s_nxt.st = s_r.ctrl.decel_en ? mps_pkg::ST_DECEL : mps_pkg::ST_INHIBIT;
               s_nxt.tmr = mps_pkg::TMW'(s_r.post); // R6
               s_nxt.bypass = 1'b0;
            end
         end
         mps_pkg::ST_DECEL: begin
            if (decel_done) begin
               s_nxt.st = mps_pkg::ST_INHIBIT; // R6
               s_nxt.tmr = mps_pkg::TMW'(s_r.post);
            end
         end
         mps_pkg::ST_INHIBIT: begin
            // Run commands are simply not looked at here
            if (tick_p) begin
               s_nxt.tmr = s_r.tmr - 1'b1; // R6 R7
               if (s_r.tmr <= mps_pkg::TMW'(1)) begin
                  s_nxt.st = mps_pkg::ST_IDLE; // R8
               end
            end
            if (!s_r.ctrl.stuck_en || !bypass_fb) begin
               s_nxt.stuck = '0;
            end else if (s_r.stuck == mps_pkg::STUCK_TICKS) begin
               flt_set[mps_pkg::FLT_STUCK] = 1'b1; // R4
            end else if (tick_p) begin
               s_nxt.stuck = s_r.stuck + 1'b1; // R4
            end
         end
         default: begin
            s_nxt.st = mps_pkg::ST_INHIBIT;
         end
      endcase

      // A fault drops the motor and still enforces the post-stop time
      if (motor_disable && running) begin
         s_nxt.st = mps_pkg::ST_INHIBIT; // R1 R11
         s_nxt.tmr = mps_pkg::TMW'(s_r.post);
         s_nxt.bypass = 1'b0;
      end

      for (int i = 0; i < mps_pkg::NCH; i++) begin
         flt_set[mps_pkg::FLT_OT + i] = cout[i].ot_fault; // R11
         flt_set[mps_pkg::FLT_SA + i] = cout[i].sens_fault_a; // R17
         flt_set[mps_pkg::FLT_SB + i] = cout[i].sens_fault_b; // R17
      end

      if (bus.wr) begin
         if (bus.addr == mps_pkg::OFF_FLT) begin
            s_nxt.flt = s_r.flt & ~bus.wdata[15:0];
         end
         if (stopped) begin // R19
            unique case (bus.addr)
               mps_pkg::OFF_CTRL: s_nxt.ctrl = bus.wdata[4:0];
               mps_pkg::OFF_PRE: s_nxt.pre = clamp(bus.wdata[15:0], mps_pkg::PRE_MIN); // R5
               mps_pkg::OFF_POST: s_nxt.post = clamp(bus.wdata[15:0], mps_pkg::POST_MIN); // R6
               mps_pkg::OFF_IVL: s_nxt.ivl_s = clamp(bus.wdata[15:0], mps_pkg::IVL_MIN); // R9
               mps_pkg::OFF_NOM: begin
                  s_nxt.mot_nom = bus.wdata[15:0];
                  s_nxt.starter_nom = bus.wdata[31:16];
               end
               default: begin
               end
            endcase
            for (int i = 0; i < mps_pkg::NCH; i++) begin
               if (bus.addr == mps_pkg::AW'(mps_pkg::OFF_CH0 + mps_pkg::CH_STRIDE * i)) begin
                  s_nxt.ccfg[i] = bus.wdata;
                  s_nxt.ccfg[i].rsvd = '0;
               end
            end
         end
      end
      // Hardware set wins over a software clear in the same cycle
      s_nxt.flt = s_nxt.flt | flt_set;

      if (bus.rd) begin
         unique case (bus.addr)
            mps_pkg::OFF_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
            mps_pkg::OFF_PRE: s_nxt.rdata = 32'(s_r.pre);
            mps_pkg::OFF_POST: s_nxt.rdata = 32'(s_r.post);
            mps_pkg::OFF_IVL: s_nxt.rdata = 32'(s_r.ivl_s);
            mps_pkg::OFF_NOM: s_nxt.rdata = {s_r.starter_nom, s_r.mot_nom};
            mps_pkg::OFF_FLT: s_nxt.rdata = 32'(s_r.flt);
            mps_pkg::OFF_STAT: s_nxt.rdata = {14'h0000, s_r.st, alarms};
            mps_pkg::OFF_TEMP: begin
               s_nxt.rdata = {cout[3].readout, cout[2].readout,
                  cout[1].readout, cout[0].readout}; // R10
            end
            default: s_nxt.rdata = '0;
         endcase
         for (int i = 0; i < mps_pkg::NCH; i++) begin
            if (bus.addr == mps_pkg::AW'(mps_pkg::OFF_CH0 + mps_pkg::CH_STRIDE * i)) begin
               s_nxt.rdata = s_r.ccfg[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0; // R20
         s_r.st <= mps_pkg::ST_IDLE;
         s_r.ctrl <= mps_pkg::CTRL_DEF;
         s_r.pre <= mps_pkg::PRE_MIN;
         s_r.post <= mps_pkg::POST_MIN;
         s_r.ivl_s <= mps_pkg::IVL_DEF;
         s_r.mot_nom <= mps_pkg::NOM_DEF;
         s_r.starter_nom <= mps_pkg::NOM_DEF;
         for (int i = 0; i < mps_pkg::NCH; i++) begin
            s_r.ccfg[i].fault_lvl <= mps_pkg::FAULT_DEF;
            s_r.ccfg[i].alarm_lvl <= mps_pkg::ALARM_DEF;
            s_r.ccfg[i].reset_lvl <= mps_pkg::RESET_DEF;
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign motor_run = (s_r.st == mps_pkg::ST_START) || (s_r.st == mps_pkg::ST_BYPASS)
      || (s_r.st == mps_pkg::ST_DECEL);
   assign bypass_close = s_r.bypass;
   assign motor_disable = |s_r.flt;
   assign faults = s_r.flt;
   always_comb begin
      for (int i = 0; i < mps_pkg::NCH; i++) begin
         alarms[i] = cout[i].ot_alarm; // R12
         alarms[4 + i] = cout[i].sens_alarm_a; // R17
         alarms[8 + i] = cout[i].sens_alarm_b; // R17
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_end_of_start;
      s_r.st == mps_pkg::ST_START && !stop_cmd && start_done;
   endsequence

   a_uc_trip: assert property (s_end_of_start and uc_bad // R1
      |=> faults[mps_pkg::FLT_UC] && !bypass_close ##1 !motor_run)
      else $error("undercurrent did not trip");
   a_uc_skip: assert property (s_end_of_start and !s_r.ctrl.uc_en && !oc_bad // R2
      && !motor_disable |=> bypass_close)
      else $error("bypass refused with check off");
   a_oc_block: assert property (s_end_of_start and oc_bad // R3
      |=> faults[mps_pkg::FLT_OC] && !bypass_close)
      else $error("overcurrent did not block bypass");
   a_stuck_cause: assert property ($rose(faults[mps_pkg::FLT_STUCK]) // R4
      |-> $past(bypass_fb) && $past(s_r.st) == mps_pkg::ST_INHIBIT)
      else $error("stuck fault without cause");
   a_pre_wait: assert property (s_r.st == mps_pkg::ST_IDLE ##1 // R5
      s_r.st == mps_pkg::ST_DELAY |-> !motor_run [*4])
      else $error("motor started without delay");
   a_inhibit_drop: assert property (s_r.st == mps_pkg::ST_INHIBIT && s_r.tmr > 17'h00001 // R7
      |=> s_r.st == mps_pkg::ST_INHIBIT && !motor_run)
      else $error("start during post-stop time");
   a_interval_trip: assert property (s_r.st == mps_pkg::ST_IDLE && start_req // R9
      && !motor_disable && s_r.ivl != '0 |=> faults[mps_pkg::FLT_IVL]
      && s_r.st == mps_pkg::ST_IDLE)
      else $error("interval fault missed");
   a_settings_lock: assert property (bus.wr && running && bus.addr == mps_pkg::OFF_PRE // R19
      |=> $stable(s_r.pre))
      else $error("setting changed while running");
   a_fault_stop: assert property (motor_disable && motor_run // R11
      |=> !motor_run && !bypass_close)
      else $error("fault did not stop motor");
endmodule
`default_nettype wire

// >>> mps_pkg.sv
`default_nettype none
package mps_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_NS = 100;
   localparam int TICK_NS = 100_000_000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam logic [16:0] TICKS_PER_S = 17'h0000A;
   localparam logic [3:0] STUCK_TICKS = 4'h5;

   // ==========================================================
   // Widths
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int TMW = 17;
   localparam int NCH = 4;

   // ==========================================================
   // Register offsets
   localparam logic [AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [AW-1:0] OFF_PRE = 8'h04;
   localparam logic [AW-1:0] OFF_POST = 8'h08;
   localparam logic [AW-1:0] OFF_IVL = 8'h0C;
   localparam logic [AW-1:0] OFF_NOM = 8'h10;
   localparam logic [AW-1:0] OFF_CH0 = 8'h14;
   localparam logic [AW-1:0] CH_STRIDE = 8'h04;
   localparam logic [AW-1:0] OFF_FLT = 8'h24;
   localparam logic [AW-1:0] OFF_STAT = 8'h28;
   localparam logic [AW-1:0] OFF_TEMP = 8'h2C;

   // ==========================================================
   // Reset values and limits (delays in 0.1 s ticks, interval in s)
   localparam logic [4:0] CTRL_DEF = 5'h07;
   localparam logic [15:0] PRE_MIN = 16'h0005;
   localparam logic [15:0] POST_MIN = 16'h0014;
   localparam logic [15:0] TIME_MAX = 16'h270F;
   localparam logic [15:0] IVL_MIN = 16'h0002;
   localparam logic [15:0] IVL_DEF = 16'h0078;
   localparam logic [15:0] NOM_DEF = 16'h0064;
   localparam logic [7:0] FAULT_DEF = 8'h8B;
   localparam logic [7:0] ALARM_DEF = 8'h7C;
   localparam logic [7:0] RESET_DEF = 8'h6C;
   localparam logic [19:0] UC_DIV = 20'h0000A;
   localparam logic [16:0] OC_MUL = 17'h00002;

   // ==========================================================
   // Fault vector layout
   localparam int FLT_UC = 0;
   localparam int FLT_OC = 1;
   localparam int FLT_STUCK = 2;
   localparam int FLT_IVL = 3;
   localparam int FLT_OT = 4;
   localparam int FLT_SA = 8;
   localparam int FLT_SB = 12;

   // ==========================================================
   // Encodings and types
   localparam logic [1:0] INST_OFF = 2'h0;
   localparam logic [1:0] OT_FAULT = 2'h0;
   localparam logic [1:0] OT_ALARM = 2'h1;
   localparam logic SF_FAULT = 1'h0;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DELAY = 6'h02,
      ST_START = 6'h04,
      ST_BYPASS = 6'h08,
      ST_DECEL = 6'h10,
      ST_INHIBIT = 6'h20
   } st_t;

   typedef struct packed {
      logic decel_en;
      logic two_wire;
      logic stuck_en;
      logic oc_en;
      logic uc_en;
   } ctrl_t;

   typedef struct packed {
      logic [7:0] reset_lvl;
      logic [7:0] alarm_lvl;
      logic [7:0] fault_lvl;
      logic [2:0] rsvd;
      logic [1:0] ot_mode;
      logic sf_mode;
      logic [1:0] installed;
   } chan_cfg_t;

   typedef struct packed {
      logic [7:0] temp;
      logic sensor_short;
      logic sensor_open;
   } chan_in_t;

   typedef struct packed {
      logic [7:0] readout;
      logic ot_fault;
      logic ot_alarm;
      logic sens_fault_a;
      logic sens_fault_b;
      logic sens_alarm_a;
      logic sens_alarm_b;
   } chan_out_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
endpackage
`default_nettype wire

// >>> temp_channel.sv
`timescale 1ns/1ns
`default_nettype none
module temp_channel (
   input wire logic clk,
   input wire logic rst_n,
   input wire mps_pkg::chan_cfg_t cfg,
   input wire mps_pkg::chan_in_t din,
   output mps_pkg::chan_out_t dout
);
   mps_pkg::chan_out_t s_r, s_nxt;
   logic en, fault_ok, alarm_ok, sf_trip;

   // ==========================================================
   // Channel evaluation
   always_comb begin
      s_nxt = s_r;
      en = cfg.installed != mps_pkg::INST_OFF; // R16
      fault_ok = cfg.ot_mode != mps_pkg::OT_ALARM; // R15
      alarm_ok = cfg.ot_mode != mps_pkg::OT_FAULT; // R15
      sf_trip = cfg.sf_mode == mps_pkg::SF_FAULT;
      s_nxt.readout = en ? din.temp : '0; // R10
      s_nxt.ot_fault = en && fault_ok && (din.temp > cfg.fault_lvl); // R11
      if (!(en && alarm_ok)) begin
         s_nxt.ot_alarm = 1'b0;
      end else if (din.temp > cfg.alarm_lvl) begin
         s_nxt.ot_alarm = 1'b1; // R12
      end else if (din.temp < cfg.reset_lvl) begin
         s_nxt.ot_alarm = 1'b0; // R13
      end
      // Short and open are told apart so each has its own code
      s_nxt.sens_fault_a = en && din.sensor_short && sf_trip; // R17
      s_nxt.sens_fault_b = en && din.sensor_open && sf_trip; // R17
      s_nxt.sens_alarm_a = en && din.sensor_short && !sf_trip; // R17
      s_nxt.sens_alarm_b = en && din.sensor_open && !sf_trip; // R17
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dout = s_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_inactive_zero: assert property (dout.readout != '0 |-> // R10
      $past(cfg.installed) != mps_pkg::INST_OFF)
      else $error("inactive channel shows a temperature");
   a_fault_level: assert property (en && fault_ok && din.temp > cfg.fault_lvl // R11
      |=> dout.ot_fault)
      else $error("overtemperature fault missed");
   a_alarm_only: assert property (en && cfg.ot_mode == mps_pkg::OT_ALARM // R12
      && din.temp > cfg.alarm_lvl |=> dout.ot_alarm && !dout.ot_fault)
      else $error("alarm mode wrong");
   a_alarm_clear: assert property (dout.ot_alarm && din.temp < cfg.reset_lvl // R13
      && din.temp <= cfg.alarm_lvl |=> !dout.ot_alarm)
      else $error("alarm not cleared below reset level");
   a_alarm_hold: assert property (dout.ot_alarm && en && alarm_ok // R13
      && din.temp >= cfg.reset_lvl |=> dout.ot_alarm)
      else $error("alarm dropped above reset level");
   a_sensor_mode: assert property (en && din.sensor_open // R17
      |=> (dout.sens_fault_b != dout.sens_alarm_b))
      else $error("sensor fault mode wrong");
endmodule
`default_nettype wire

// >>> mps_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Soft-start ramp and bypass contactor stand-in
module mps_partner (
   input wire logic clk,
   input wire logic motor_run,
   input wire logic bypass_close,
   input wire logic stuck,
   output logic bypass_fb,
   output logic start_done
);
   logic [3:0] ramp_r = 4'h0;
   logic run_r = 1'b0;
   logic fb_r = 1'b0;
   logic done_r = 1'b0;

   assign bypass_fb = fb_r;
   assign start_done = done_r;

   // Ramp ends a fixed nine cycles after the motor is energised
   always @(posedge clk) begin
      run_r <= motor_run;
      done_r <= !(motor_run && !run_r) && (ramp_r == 4'h1);
      if (motor_run && !run_r) begin
         ramp_r <= 4'h8;
      end else if (ramp_r != 4'h0) begin
         ramp_r <= ramp_r - 4'h1;
      end
      // Welded contacts keep reporting closed after the open command
      fb_r <= bypass_close | (stuck & fb_r);
   end
endmodule
`default_nettype wire

// >>> motor_protection_supervisor_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module motor_protection_supervisor_tb;
   localparam int TK = 4;
   localparam logic [7:0] RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h30,
      8'h24, 8'h28};
   localparam logic [31:0] RE [9] = '{32'h7, 32'h5, 32'h14, 32'h78, 32'h00640064,
      32'h6C7C8B00, 32'h0, 32'h0, 32'h1000};
   localparam logic [31:0] CFG [4] = '{32'h6C7C8B01, 32'h6C7C8B0E, 32'h6C7C8B11,
      32'h6C7C8B00};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   mps_pkg::bus_req_t bus = '0;
   logic run_cmd = 1'b0;
   logic run_level = 1'b0;
   logic stop_cmd = 1'b0;
   logic decel_done = 1'b0;
   logic stuck = 1'b0;
   logic [15:0] cur = 16'h0032;
   mps_pkg::chan_in_t [3:0] chan_in = '0;
   logic [31:0] rdata;
   logic [31:0] d;
   logic start_done, bypass_fb, motor_run, bypass_close, motor_disable;
   logic [15:0] faults;
   logic [11:0] alarms;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   int k;

   motor_protection_supervisor #(.TICK_CYCLES(TK)) u_motor_protection_supervisor (
      .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .run_cmd(run_cmd),
      .run_level(run_level), .stop_cmd(stop_cmd), .start_done(start_done),
      .decel_done(decel_done), .bypass_fb(bypass_fb), .motor_current(cur),
      .chan_in(chan_in), .motor_run(motor_run), .bypass_close(bypass_close),
      .motor_disable(motor_disable), .faults(faults), .alarms(alarms)
   );
   mps_partner u_mps_partner (
      .clk(clk), .motor_run(motor_run), .bypass_close(bypass_close),
      .stuck(stuck), .bypass_fb(bypass_fb), .start_done(start_done)
   );

   initial begin
      forever #50 clk = ~clk;
   end

   // ==========================================================
   // Run control
   task final_report;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Whole run is near 1900 cycles; the ceiling leaves ample slack
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         n_mismatch++;
         final_report;
      end
   end

   // ==========================================================
   // Bus and command helpers
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask

   task pulse(input logic r);
      @(posedge clk);
      if (r) begin
         run_cmd <= 1'b1;
      end else begin
         stop_cmd <= 1'b1;
      end
      @(posedge clk);
      run_cmd <= 1'b0;
      stop_cmd <= 1'b0;
   endtask

   task wait_run(input int m);
      k = 0;
      while (motor_run !== 1'b1 && k < m) begin
         @(posedge clk);
         k++;
      end
   endtask

   // Start, then let the ramp end and the bypass decision land
   task start_motor;
      pulse(1'b1);
      wait_run(40);
      `CHK(k >= 4 * TK && k <= 7 * TK, 1'b1)
      repeat (14) @(posedge clk);
   endtask

   task clear;
      wr(8'h24, 32'hFFFF);
      repeat (110) @(posedge clk);
   endtask

   // ==========================================================
   // Scenarios
   task t_regs;
      `CHK({motor_run, faults, alarms}, 29'h0)
      for (int i = 0; i < 9; i++) begin
         rd(RA[i], d);
         `CHK(d, RE[i])
      end
   endtask

   task t_run;
      wr(8'h0C, 32'h2);
      start_motor;
      `CHK({bypass_close, faults}, 17'h10000)
      wr(8'h04, 32'h50);
      rd(8'h04, d);
      `CHK(d, 32'h5)
      pulse(1'b0);
      repeat (2) @(posedge clk);
      `CHK({motor_run, bypass_close}, 2'b00)
      repeat (8) @(posedge clk);
      pulse(1'b1);
      repeat (140) @(posedge clk);
      `CHK(motor_run, 1'b0)
   endtask

   task t_two;
      wr(8'h00, 32'hF);
      start_motor;
      run_level <= 1'b1;
      pulse(1'b0);
      repeat (70) @(posedge clk);
      `CHK(motor_run, 1'b0)
      wait_run(80);
      `CHK(motor_run, 1'b1)
      run_level <= 1'b0;
      repeat (14) @(posedge clk);
      pulse(1'b0);
      repeat (110) @(posedge clk);
      wr(8'h00, 32'h7);
   endtask

   // Post-stop time must be counted from the end of the deceleration ramp
   task t_decel;
      wr(8'h00, 32'h17);
      start_motor;
      pulse(1'b0);
      repeat (90) @(posedge clk);
      `CHK(motor_run, 1'b1)
      decel_done <= 1'b1;
      @(posedge clk);
      decel_done <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(motor_run, 1'b0)
      pulse(1'b1);
      repeat (60) @(posedge clk);
      `CHK(motor_run, 1'b0)
      repeat (30) @(posedge clk);
      wr(8'h00, 32'h7);
   endtask

   task t_bypass;
      cur <= 16'h0005;
      start_motor;
      `CHK({faults[0], bypass_close, motor_disable}, 3'b101)
      clear;
      wr(8'h00, 32'h6);
      start_motor;
      `CHK({faults[0], bypass_close}, 2'b01)
      pulse(1'b0);
      repeat (110) @(posedge clk);
      wr(8'h00, 32'h7);
      cur <= 16'h00C8;
      start_motor;
      `CHK({faults[1], bypass_close}, 2'b10)
      clear;
      cur <= 16'h0032;
      start_motor;
      stuck <= 1'b1;
      pulse(1'b0);
      repeat (5 * TK + 8) @(posedge clk);
      `CHK({faults[2], motor_disable}, 2'b11)
      stuck <= 1'b0;
      clear;
   endtask

   task t_ivl;
      wr(8'h0C, 32'hA);
      start_motor;
      pulse(1'b0);
      repeat (110) @(posedge clk);
      pulse(1'b1);
      repeat (3) @(posedge clk);
      `CHK(faults[3], 1'b1)
      repeat (40) @(posedge clk);
      `CHK(motor_run, 1'b0)
      wr(8'h24, 32'hFFFF);
      wr(8'h0C, 32'h2);
      repeat (300) @(posedge clk);
   endtask

   // Alarm levels stay above reset levels in every channel setting
   task t_temp;
      for (int i = 0; i < 4; i++) begin
         wr(8'h14 + 8'(4 * i), CFG[i]);
      end
      start_motor;
      chan_in[1].temp <= 8'h82;
      chan_in[2].temp <= 8'h82;
      chan_in[3] <= '{temp: 8'hC8, sensor_short: 1'b1, sensor_open: 1'b0};
      repeat (3) @(posedge clk);
      `CHK(alarms, 12'h006)
      `CHK({motor_run, faults}, 17'h10000)
      rd(8'h2C, d);
      `CHK(d, 32'h00828200)
      chan_in[1].temp <= 8'h6C;
      repeat (3) @(posedge clk);
      `CHK(alarms[1], 1'b1)
      chan_in[1].temp <= 8'h6B;
      repeat (3) @(posedge clk);
      `CHK(alarms[1], 1'b0)
      chan_in[1].sensor_open <= 1'b1;
      chan_in[2].temp <= 8'h8C;
      repeat (4) @(posedge clk);
      `CHK({alarms, faults}, 28'h2040040)
      `CHK({motor_run, motor_disable}, 2'b01)
      chan_in[0] <= '{temp: 8'h8B, sensor_short: 1'b1, sensor_open: 1'b0};
      repeat (3) @(posedge clk);
      `CHK(faults, 16'h0140)
      chan_in[0].temp <= 8'h8C;
      repeat (3) @(posedge clk);
      `CHK({alarms[0], faults}, 17'h00150)
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs;
      t_run;
      t_two;
      t_decel;
      t_bypass;
      t_ivl;
      t_temp;
      final_report;
   end
endmodule
`default_nettype wire
